// ==== logic/fer_classify.sv ====
// exception classification: which flags set and which fix-up applies
`timescale 1ns/1ps
module fer_classify (
  // raw detections of one instruction, in detection order
  input  wire logic [5:0]         raw,
  input  wire logic [5:0]         mask,
  input  wire logic               tiny,
  // outcome
  output logic [5:0]              set_bits,
  output logic                    unmasked_hit,
  output fer_pkg::fer_fix_t       fixup
);
  import fer_pkg::*;

  // map a masked class to its default result
  function automatic fer_fix_t fer_fix_of(input int cls, input logic tny);
    fer_fix_t f;
    f = FER_FX_NONE;
    unique case (cls)
      FER_BIT_INV: f = FER_FX_QNAN;
      FER_BIT_ZDV: f = FER_FX_INF;
      FER_BIT_OVF: f = FER_FX_INF;
      FER_BIT_UNF: f = tny ? FER_FX_ZERO : FER_FX_DENORM;
      FER_BIT_PRC: f = FER_FX_ROUNDED;
      default:     f = FER_FX_NONE;
    endcase
    return f;
  endfunction : fer_fix_of

  // masked classes keep the walk going; the first unmasked one ends it
  always_comb begin
    logic stop;
    stop         = 1'b0;
    set_bits     = '0;
    unmasked_hit = 1'b0;
    fixup        = FER_FX_NONE;
    for (int i = 0; i < FER_NCLS; i++) begin
      if (raw[i] && !stop) begin
        set_bits[i] = 1'b1;
        if (mask[i]) begin
          if (fer_fix_of(i, tiny) != FER_FX_NONE) begin
            fixup = fer_fix_of(i, tiny);
          end
        end else begin
          stop         = 1'b1;
          unmasked_hit = 1'b1;
          fixup        = FER_FX_NONE;
        end
      end
    end
  end
endmodule : fer_classify

// ==== logic/fer_sync.sv ====
// two-flop synchroniser for a slow level input
`timescale 1ns/1ps
module fer_sync #(
  parameter int STAGES = fer_pkg::FER_SYNC_STAGES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // level in and synchronised level out
  input  wire logic d,
  output logic      q
);
  import fer_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0] sh;
  } fer_sync_st_t;

  fer_sync_st_t s_q;
  fer_sync_st_t s_d;

  // refuse depths that give no metastability margin
  if (STAGES < 2) begin : g_chk
    $error("fer_sync: STAGES must be at least 2");
  end

  // shift chain; only the last stage is read outside
  always_comb begin
    s_d    = s_q;
    s_d.sh = {s_q.sh[STAGES-2:0], d};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.sh[STAGES-1];
endmodule : fer_sync

// ==== logic/fer_unit.sv ====
// numeric exception flags, masks, error pin and freeze control
`timescale 1ns/1ps
module fer_unit (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // instruction stream
  input  wire logic                      op_valid,
  input  wire fer_pkg::fer_op_t          op_kind,
  input  wire logic                      op_no_wait,
  output logic                           op_ready,
  // datapath detections for an arithmetic op
  input  wire logic [5:0]                exc_raw,
  input  wire logic                      stack_fault_exc,
  input  wire logic                      arith_invalid_exc,
  input  wire logic                      exc_tiny,
  input  wire logic                      exc_deferred,
  // images for restore, environment load and control load
  input  wire logic [6:0]                load_status,
  input  wire logic [7:0]                load_control,
  // state view
  output logic [5:0]                     status_flags,
  output logic                           stack_fault_flag,
  output logic [5:0]                     control_masks,
  output fer_pkg::fer_round_t            round_mode,
  // per-instruction outcome
  output logic                           fixup_valid,
  output fer_pkg::fer_fix_t              fixup_code,
  output logic                           abort_instr,
  output logic                           native_trap,
  output logic                           handler_entry,
  // system pins
  input  wire logic                      native_error_enable,
  input  wire logic                      ignore_numeric_error_in,
  input  wire logic                      interrupt_request_in,
  output logic                           fpu_error_out,
  output logic                           cpu_freeze
);
  import fer_pkg::*;

  typedef struct packed {
    logic [5:0]  flags;
    logic        sf;
    logic [5:0]  masks;
    fer_round_t  rnd;
    logic        err;
    logic        frozen;
    logic        trapped;
    logic        fix_v;
    fer_fix_t    fix;
    logic        abort;
    logic        trap;
    logic        entry;
  } fer_st_t;

  fer_st_t     s_q;
  fer_st_t     s_d;
  logic        ign_s;
  logic [5:0]  raw_all;
  logic [5:0]  cls_set;
  logic        cls_hit;
  fer_fix_t    cls_fix;
  logic        pend;
  logic        waitable;
  logic        blocked;
  logic        fire;

  // ignore pin crosses two flops before any logic sees it
  fer_sync #(
    .STAGES (FER_SYNC_STAGES)
  ) u_ign_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (ignore_numeric_error_in),
    .q        (ign_s)
  );

  // invalid class gathers both subtypes
  always_comb begin
    raw_all              = exc_raw;
    raw_all[FER_BIT_INV] = exc_raw[FER_BIT_INV] | stack_fault_exc
                           | arith_invalid_exc;
  end

  fer_classify u_cls (
    .raw          (raw_all),
    .mask         (s_q.masks),
    .tiny         (exc_tiny),
    .set_bits     (cls_set),
    .unmasked_hit (cls_hit),
    .fixup        (cls_fix)
  );

  // pending means a set flag whose class is unmasked
  assign pend     = |(s_q.flags & ~s_q.masks);
  assign waitable = (op_kind != FER_OP_NONE) && !op_no_wait;
  // ignore only helps in compatibility mode; native mode always blocks
  assign blocked  = pend && waitable
                    && (native_error_enable || !ign_s);
  assign op_ready = !s_q.frozen && !blocked;
  assign fire     = op_valid && op_ready;

  // next-state logic for flags, control, error pin and freeze
  always_comb begin
    s_d       = s_q;
    s_d.fix_v = 1'b0;
    s_d.fix   = FER_FX_NONE;
    s_d.abort = 1'b0;
    s_d.trap  = 1'b0;
    s_d.entry = 1'b0;
    if (fire) begin
      unique case (op_kind)
        FER_OP_NONE, FER_OP_WAIT: begin
        end
        FER_OP_ARITH: begin
          s_d.flags = s_q.flags | cls_set;
          s_d.sf    = s_q.sf | (stack_fault_exc & cls_set[FER_BIT_INV]);
          s_d.fix_v = !cls_hit;
          s_d.fix   = cls_fix;
          s_d.abort = cls_hit;
          // immediate class raises the pin at once
          if (cls_hit && !native_error_enable && !exc_deferred) begin
            s_d.err = 1'b1;
          end
        end
        FER_OP_CLEAR: begin
          s_d.flags = FER_FLAGS_RST;
          s_d.sf    = 1'b0;
        end
        FER_OP_REINIT, FER_OP_SAVE: begin
          // save leaves the unit reinitialised as well
          s_d.flags = FER_FLAGS_RST;
          s_d.sf    = 1'b0;
          s_d.masks = FER_MASK_RST;
          s_d.rnd   = FER_RND_NEAR;
        end
        FER_OP_RESTORE, FER_OP_LDENV: begin
          s_d.flags = load_status[FER_NCLS-1:0];
          s_d.sf    = load_status[FER_BIT_SF];
          s_d.masks = load_control[FER_NCLS-1:0];
          s_d.rnd   = fer_round_t'(load_control[FER_RND_MSB:FER_RND_LSB]);
        end
        FER_OP_LDCW: begin
          s_d.masks = load_control[FER_NCLS-1:0];
          s_d.rnd   = fer_round_t'(
                      load_control[FER_RND_MSB:FER_RND_LSB]);
        end
        default: begin
        end
      endcase
    end
    // deferred class raises the pin when the next numeric op shows up
    if (op_valid && waitable && pend && !native_error_enable) begin
      s_d.err = 1'b1;
    end
    // a blocked op stops the processor in compatibility mode
    if (op_valid && blocked && !native_error_enable && !s_q.frozen) begin
      s_d.frozen = 1'b1;
    end
    // native mode: one trap per pending error, no pin
    if (op_valid && blocked && native_error_enable && !s_q.trapped) begin
      s_d.trap    = 1'b1;
      s_d.trapped = 1'b1;
    end
    // any interrupt request lifts the freeze into the handler
    if (s_q.frozen) begin
      if (interrupt_request_in) begin
        s_d.frozen = 1'b0;
        s_d.entry  = 1'b1;
      end else if (ign_s || !pend) begin
        s_d.frozen = 1'b0;
      end
    end
    // pin and trap latch drop only once the unmasked error is gone
    if (~|(s_d.flags & ~s_d.masks)) begin
      s_d.err     = 1'b0;
      s_d.trapped = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q         <= '0;
      s_q.flags   <= FER_FLAGS_RST;
      s_q.masks   <= FER_MASK_RST;
      s_q.rnd     <= FER_RND_NEAR;
      s_q.fix     <= FER_FX_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // registered outputs
  assign status_flags     = s_q.flags;
  assign stack_fault_flag = s_q.sf;
  assign control_masks    = s_q.masks;
  assign round_mode       = s_q.rnd;
  assign fixup_valid      = s_q.fix_v;
  assign fixup_code       = s_q.fix;
  assign abort_instr      = s_q.abort;
  assign native_trap      = s_q.trap;
  assign handler_entry    = s_q.entry;
  assign fpu_error_out    = s_q.err;
  assign cpu_freeze       = s_q.frozen;

  default clocking fer_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_flags_sticky: assert property (
    (op_kind != FER_OP_CLEAR && op_kind != FER_OP_REINIT
     && op_kind != FER_OP_SAVE && op_kind != FER_OP_RESTORE
     && op_kind != FER_OP_LDENV) || !fire
    |=> ((s_q.flags & $past(s_q.flags)) == $past(s_q.flags)))
    else $error("flag dropped without a clearing op");

  a_clear_zeroes: assert property (
    fire && op_kind == FER_OP_CLEAR |=> s_q.flags == FER_FLAGS_RST)
    else $error("clear op left flags set");

  a_masked_quiet: assert property (
    fire && op_kind == FER_OP_ARITH && !pend
    && ((raw_all & ~s_q.masks) == 6'h00)
    |=> !fpu_error_out && !abort_instr && fixup_valid)
    else $error("masked exception gave an external sign");

  a_unmasked_abort: assert property (
    fire && op_kind == FER_OP_ARITH && ((raw_all & ~s_q.masks) != 6'h00)
    |=> abort_instr && !fixup_valid)
    else $error("unmasked exception did not abort");

  a_immediate_err: assert property (
    fire && op_kind == FER_OP_ARITH && cls_hit && !native_error_enable
    && !exc_deferred |=> fpu_error_out)
    else $error("immediate error not shown on pin");

  a_err_holds: assert property (
    fpu_error_out && pend && !fire |=> fpu_error_out)
    else $error("error pin fell while error pending");

  a_err_needs_pend: assert property (
    fpu_error_out |-> pend)
    else $error("error pin high with nothing pending");

  a_freeze_holds: assert property (
    cpu_freeze && pend && !ign_s && !interrupt_request_in |=> cpu_freeze)
    else $error("freeze lifted without an interrupt");

  a_freeze_release: assert property (
    cpu_freeze && interrupt_request_in |=> !cpu_freeze && handler_entry)
    else $error("interrupt did not release freeze");

  a_ignore_passes: assert property (
    !native_error_enable && ign_s && !s_q.frozen |-> op_ready)
    else $error("ignore active yet op refused");

  a_nowait_passes: assert property (
    op_valid && op_no_wait && !s_q.frozen |-> fire)
    else $error("no-wait op refused");
endmodule : fer_unit

// ==== shared/fer_pkg.sv ====
// constants and types shared by the numeric exception reporting block
package fer_pkg;
  // number of exception classes and their flag / mask positions
  localparam int FER_NCLS    = 6;
  localparam int FER_BIT_INV = 0;
  localparam int FER_BIT_DEN = 1;
  localparam int FER_BIT_ZDV = 2;
  localparam int FER_BIT_OVF = 3;
  localparam int FER_BIT_UNF = 4;
  localparam int FER_BIT_PRC = 5;
  // stack-fault subtype bit position in the loadable status image
  localparam int FER_BIT_SF  = 6;
  localparam int FER_STW     = 7;
  // control image: masks in low bits, rounding field above them
  localparam int FER_CTW     = 8;
  localparam int FER_RND_LSB = 6;
  localparam int FER_RND_MSB = 7;
  // reset values: everything masked, no flags
  localparam logic [5:0] FER_MASK_RST  = 6'h3f;
  localparam logic [5:0] FER_FLAGS_RST = 6'h00;
  // synchroniser depth for the ignore-error pin
  localparam int FER_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    FER_RND_NEAR,
    FER_RND_CHOP,
    FER_RND_UP,
    FER_RND_DOWN
  } fer_round_t;

  typedef enum logic [3:0] {
    FER_OP_NONE,
    FER_OP_ARITH,
    FER_OP_WAIT,
    FER_OP_CLEAR,
    FER_OP_REINIT,
    FER_OP_SAVE,
    FER_OP_RESTORE,
    FER_OP_LDENV,
    FER_OP_LDCW
  } fer_op_t;

  typedef enum logic [2:0] {
    FER_FX_NONE,
    FER_FX_QNAN,
    FER_FX_INF,
    FER_FX_DENORM,
    FER_FX_ZERO,
    FER_FX_ROUNDED
  } fer_fix_t;
endpackage : fer_pkg

// ==== verif/fer_pic_model.sv ====
// interrupt controller stand-in between error pin and request input
`timescale 1ns/1ps
module fer_pic_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // error pin in, request out
  input  wire logic       err_pin,
  output logic            irq,
  // line enable, latency, port clear, other source
  input  wire logic       line_en,
  input  wire logic [3:0] lat,
  input  wire logic       port_clr,
  input  wire logic       other_irq
);
  logic       err_q;
  logic       req_q;
  logic [3:0] cnt_q;
  // edge latch: a steady error pin does not re-raise after a port clear
  always_ff @(posedge core_clk) begin
    err_q <= err_pin;
    if (rst || port_clr) begin
      req_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (err_pin && !err_q) begin
      req_q <= 1'b1;
    end else if (req_q && cnt_q != lat) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // latency stands for the routing delay through the controller
  assign irq = other_irq || (req_q && line_en && cnt_q == lat);
endmodule : fer_pic_model

// ==== verif/test_fpu_exception_reporting.sv ====
// self-checking bench for the numeric exception reporting unit
`timescale 1ns/1ps
module test_fpu_exception_reporting;
  import fer_pkg::*;
  // design and partner signals
  logic       core_clk, rst, op_valid, op_no_wait, op_ready;
  logic       stack_fault_exc, arith_invalid_exc, exc_tiny, exc_deferred;
  logic       stack_fault_flag, fixup_valid, abort_instr, handler_entry;
  logic       native_trap;
  logic       native_error_enable, fpu_error_out, cpu_freeze;
  logic       ignore_numeric_error_in, interrupt_request_in;
  logic       line_en, port_clr, other_irq;
  logic [5:0] exc_raw, status_flags, control_masks;
  logic [6:0] load_status, ls_v;
  logic [7:0] load_control, lc_v;
  logic [15:0] lf;
  logic       sf_v, tiny_v, defer_v;
  fer_op_t    op_kind;
  fer_round_t round_mode;
  fer_fix_t   fixup_code;
  // bench model state
  int bad_count = 0, num_checks = 0, flags_m = 0, rnd_m = 0, sf_m = 0;
  int masks_m = FER_MASK_RST, defer_m = 0;
  // case tables
  logic [5:0] fr [5] = '{6'h04, 6'h10, 6'h10, 6'h30, 6'h02};
  fer_fix_t   fc [5] = '{FER_FX_INF, FER_FX_DENORM, FER_FX_ZERO,
                         FER_FX_ROUNDED, FER_FX_NONE};
  fer_op_t    cl [5] = '{FER_OP_CLEAR, FER_OP_REINIT, FER_OP_SAVE,
                         FER_OP_RESTORE, FER_OP_LDENV};

  fer_unit fer_unit_i (
    .core_clk(core_clk), .rst(rst), .op_valid(op_valid),
    .op_kind(op_kind), .op_no_wait(op_no_wait), .op_ready(op_ready),
    .exc_raw(exc_raw), .stack_fault_exc(stack_fault_exc),
    .arith_invalid_exc(arith_invalid_exc), .exc_tiny(exc_tiny),
    .exc_deferred(exc_deferred), .load_status(load_status),
    .load_control(load_control), .status_flags(status_flags),
    .stack_fault_flag(stack_fault_flag), .control_masks(control_masks),
    .round_mode(round_mode), .fixup_valid(fixup_valid),
    .fixup_code(fixup_code), .abort_instr(abort_instr),
    .native_trap(native_trap), .handler_entry(handler_entry),
    .native_error_enable(native_error_enable),
    .ignore_numeric_error_in(ignore_numeric_error_in),
    .interrupt_request_in(interrupt_request_in),
    .fpu_error_out(fpu_error_out), .cpu_freeze(cpu_freeze));

  fer_pic_model fer_pic_model_i (
    .core_clk(core_clk), .rst(rst), .err_pin(fpu_error_out),
    .irq(interrupt_request_in), .line_en(line_en), .lat(4'h3),
    .port_clr(port_clr), .other_irq(other_irq));

  // 200 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // compare one value, count it, report a mismatch
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  function automatic logic [15:0] step(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step

  // visible state against the model; a deferred error keeps the pin low
  task automatic chk_state();
    int pend;
    pend = ((flags_m & ~masks_m & 'h3f) != 0 && defer_m == 0
            && native_error_enable == 1'b0) ? 1 : 0;
    chk("flags", 8'(status_flags), 8'(flags_m));
    chk("masks", 8'(control_masks), 8'(masks_m));
    chk("round", 8'(round_mode), 8'(rnd_m));
    chk("error", 8'(fpu_error_out), 8'(pend));
    chk("freeze", 8'(cpu_freeze), 8'h00);
  endtask : chk_state

  // present one instruction, hold it until taken or for at most four cycles, update model, check
  task automatic op(fer_op_t k, logic [5:0] r, logic nw);
    int   n;
    int   hit;
    int   fx;
    logic took;
    took = 1'b0;
    hit = 0;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    exc_raw <= r;
    op_no_wait <= nw;
    exc_tiny <= tiny_v;
    exc_deferred <= defer_v;
    stack_fault_exc <= r[0] & sf_v;
    arith_invalid_exc <= r[0] & ~sf_v;
    load_status <= ls_v;
    load_control <= lc_v;
    for (n = 0; n < 4 && !took; n++) begin
      #1;
      took = (op_ready === 1'b1);
      @(posedge core_clk);
    end
    op_valid <= 1'b0;
    #1;
    // detection walk stops at the first unmasked class
    if (k == FER_OP_ARITH) begin
      for (n = 0; n < 6; n++) begin
        if (hit == 0 && r[n]) begin
          flags_m |= 1 << n;
          hit = masks_m[n] ? 0 : 1;
        end
      end
      if (r[0] && sf_v) sf_m = 1;
      if (hit != 0 && defer_v) defer_m = 1;
    end else if (k == FER_OP_CLEAR) begin
      flags_m = 0;
    end else if (k == FER_OP_REINIT || k == FER_OP_SAVE) begin
      flags_m = 0;
      masks_m = FER_MASK_RST;
      rnd_m = 0;
    end else if (k != FER_OP_WAIT) begin
      if (k != FER_OP_LDCW) flags_m = ls_v[5:0];
      masks_m = lc_v[5:0];
      rnd_m = lc_v[7:6];
    end
    fx = (k == FER_OP_ARITH && hit == 0) ? 1 : 0;
    chk("taken", 8'(took), 8'h01);
    chk("abort", 8'(abort_instr), 8'(hit));
    chk("fixup", 8'(fixup_valid), 8'(fx));
    chk_state();
  endtask : op

  // park a wait behind a pending error until the handler is entered
  task automatic freeze_hold(int hold);
    int n;
    defer_m = 0;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_kind <= FER_OP_WAIT;
    op_no_wait <= 1'b0;
    #1;
    chk("ready", 8'(op_ready), 8'h00);
    repeat (hold + 1) @(posedge core_clk);
    #1;
    chk("freeze", 8'(cpu_freeze), 8'h01);
    @(posedge core_clk);
    other_irq <= (hold > 0);
    #1;
    for (n = 0; n < 40 && handler_entry !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("entry", 8'(handler_entry), 8'h01);
    chk("error", 8'(fpu_error_out), 8'h01);
    // port write first, unit clear after: early hardware needs this order
    @(posedge core_clk);
    op_valid <= 1'b0;
    port_clr <= 1'b1;
    @(posedge core_clk);
    port_clr <= 1'b0;
    other_irq <= 1'b0;
    op(FER_OP_CLEAR, 6'h00, 1'b1);
  endtask : freeze_hold

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    int i;
    {op_valid, op_no_wait, exc_tiny, exc_deferred, stack_fault_exc} = '0;
    {arith_invalid_exc, native_error_enable, ignore_numeric_error_in} = '0;
    {port_clr, other_irq, sf_v, tiny_v, defer_v} = '0;
    line_en = 1'b1;
    op_kind = FER_OP_NONE;
    exc_raw = 6'h00;
    load_status = 7'h00;
    load_control = 8'h00;
    ls_v = 7'h00;
    lc_v = 8'h3f;
    lf = 16'h11ed;
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk_state();
    chk("ready", 8'(op_ready), 8'h01);
    // masked random traffic: flags gather, no outside sign
    repeat (40) begin
      lf = step(lf);
      sf_v = lf[8];
      op(FER_OP_ARITH, lf[5:0], 1'b0);
    end
    chk("stack", 8'(stack_fault_flag), 8'(sf_m));
    sf_v = 1'b0;
    // default result for the masked divide, underflow, precision and denormal classes, last class wins
    for (i = 0; i < 5; i++) begin
      tiny_v = (i == 2);
      op(FER_OP_ARITH, fr[i], 1'b0);
      chk("code", 8'(fixup_code), 8'(fc[i]));
    end
    tiny_v = 1'b0;
    for (i = 0; i < 4; i++) begin
      lc_v = {i[1:0], 6'h3f};
      op(FER_OP_LDCW, 6'h00, 1'b0);
    end
    // flags survive plain work and drop only through the clearing family
    for (i = 0; i < 5; i++) begin
      op(FER_OP_ARITH, 6'h21, 1'b0);
      op(FER_OP_ARITH, 6'h00, 1'b0);
      lf = step(lf);
      ls_v = lf[6:0];
      op(cl[i], 6'h00, 1'b0);
    end
    // a random loaded image must not leave a divide flag to unmask
    op(FER_OP_CLEAR, 6'h00, 1'b0);
    // unmasked divide by zero: abort, error pin, freeze, handler
    lc_v = 8'h3b;
    op(FER_OP_LDCW, 6'h00, 1'b0);
    op(FER_OP_ARITH, 6'h04, 1'b0);
    op(FER_OP_WAIT, 6'h00, 1'b1);
    freeze_hold(0);
    // request line disabled: only another source frees the core
    @(posedge core_clk);
    line_en <= 1'b0;
    op(FER_OP_ARITH, 6'h04, 1'b0);
    freeze_hold(20);
    @(posedge core_clk);
    line_en <= 1'b1;
    ignore_numeric_error_in <= 1'b1;
    op(FER_OP_ARITH, 6'h04, 1'b0);
    op(FER_OP_WAIT, 6'h00, 1'b0);
    // drop the stale request so the deferred case needs a fresh edge
    @(posedge core_clk);
    port_clr <= 1'b1;
    @(posedge core_clk);
    port_clr <= 1'b0;
    op(FER_OP_CLEAR, 6'h00, 1'b1);
    @(posedge core_clk);
    ignore_numeric_error_in <= 1'b0;
    // deferred report: pin waits for the next numeric op
    defer_v = 1'b1;
    op(FER_OP_ARITH, 6'h04, 1'b0);
    defer_v = 1'b0;
    freeze_hold(0);
    // native mode: pin stays low, a blocked op gets one trap pulse
    @(posedge core_clk);
    native_error_enable <= 1'b1;
    op(FER_OP_ARITH, 6'h04, 1'b0);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_kind <= FER_OP_WAIT;
    op_no_wait <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("trap", 8'(native_trap), 8'h01);
    chk("ready", 8'(op_ready), 8'h00);
    chk("error", 8'(fpu_error_out), 8'h00);
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    chk("trap", 8'(native_trap), 8'h00);
    op(FER_OP_CLEAR, 6'h00, 1'b1);
    tally_and_finish();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : test_fpu_exception_reporting
